/* adcc_top.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int NUM_CHANNELS = 8,
  parameter int RC_DIV = 1000
)
(
  input wire logic SYS_CLK, // 250 MHz clock
  input wire logic SRST, // Synchronous reset, active high
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB write
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error for unmapped address
  input wire logic [9:0] COMPARATOR_HIGH, // Comparator: sample above trial level
  output logic [9:0] TRIAL_LEVEL, // Trial level to the internal DAC
  output logic [2:0] CHANNEL_ROUTE, // Channel steered to sample switch
  output logic SAMPLE_CONNECT, // Hold capacitor connected to channel
  output logic MODULE_POWERED, // Analog module powered
  output logic RC_OSC_ENABLE, // Internal RC oscillator running
  output logic [7:0] ANALOG_PINS, // Pins used as analog channels
  output logic POS_REF_EXTERNAL, // Positive reference taken from pos_ref_pin
  output logic NEG_REF_EXTERNAL, // Negative reference taken from neg_ref_pin
  output logic CONVERTER_IRQ_FLAG // Sticky completion flag
);

  if (NUM_CHANNELS != 5 && NUM_CHANNELS != 8)
  begin : g_bad_channels
    $error("NUM_CHANNELS must be 5 or 8");
  end
  if (RC_DIV < 2 || RC_DIV > 65535)
  begin : g_bad_rc_div
    $error("RC_DIV out of range");
  end

  logic [7:0] control_r, control_nxt;
  logic [7:0] port_config_r, port_config_nxt;
  logic [7:0] result_high_r, result_low_r;
  logic irq_flag_r;
  logic [15:0] div_cnt_r;
  logic [3:0] step_r;
  logic [9:0] sar_r;
  logic [9:0] trial_r;
  adcc_state_t state_r;

  wire bus_access = PSEL && PENABLE;
  // Writes land at the edge that completes the access, exactly once
  wire bus_wr = bus_access && PREADY && PWRITE;
  wire hit_control = PADDR == ADDR_CONTROL;
  wire hit_config = PADDR == ADDR_PORT_CONFIG;
  wire hit_high = PADDR == ADDR_RESULT_HIGH;
  wire hit_low = PADDR == ADDR_RESULT_LOW;
  wire hit_status = PADDR == ADDR_STATUS;
  wire hit_any = hit_control || hit_config || hit_high || hit_low || hit_status;
  wire wr_control = bus_wr && hit_control;
  wire wr_config = bus_wr && hit_config;
  wire wr_status = bus_wr && hit_status;

  wire [1:0] clksel = control_r[CLKSEL_LSB +: 2];
  wire powered = control_r[POWER_BIT];
  wire [3:0] pcfg = port_config_r[3:0];

  // Divider period in system clocks for one conversion-clock period
  wire [15:0] div_period =
    (clksel == 2'(CLK_DIV2)) ? 16'h0002 :
    (clksel == 2'(CLK_DIV8)) ? 16'h0008 :
    (clksel == 2'(CLK_DIV32)) ? 16'h0020 : 16'(RC_DIV);
  wire tick = div_cnt_r >= div_period - 16'h0001;

  // Start honoured only with power already on and idle
  wire sw_start = wr_control && PWDATA[START_BIT] && PWDATA[POWER_BIT];
  wire sw_abort = wr_control && !sw_start;
  wire converting = state_r == ST_CONVERT;
  wire last_tick = converting && tick && (step_r == 4'(CONV_PERIODS - 1));
  wire conv_abort = converting && (sw_abort || !powered);
  wire conv_done = last_tick && !conv_abort;
  wire start_ok = sw_start && powered && state_r == ST_IDLE;
  // Start bit mirrors a running conversion, so a refused start never sticks
  wire start_nxt = start_ok || (converting && !conv_abort && !last_tick);
  wire [9:0] sar_next = COMPARATOR_HIGH == 10'h000 ? sar_r : (sar_r | trial_r);

  // Control: set by software, start bit owned by the sequencer
  always_comb
  begin
    control_nxt = control_r;
    if (wr_control)
      control_nxt = PWDATA[7:0] & CONTROL_MASK;
    control_nxt[START_BIT] = start_nxt;
  end

  always_comb
  begin
    port_config_nxt = port_config_r;
    if (wr_config)
      port_config_nxt = PWDATA[7:0] & PORT_CONFIG_MASK;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      control_r <= CONTROL_RESET;
      port_config_r <= PORT_CONFIG_RESET;
    end
    else
    begin
      control_r <= control_nxt;
      port_config_r <= port_config_nxt;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || tick || state_r == ST_IDLE)
      div_cnt_r <= 16'h0000;
    else
      div_cnt_r <= div_cnt_r + 16'h0001;
  end

  // Step 0 loads the first trial with the switch open, steps 1..10 resolve one bit each, step 11 settles
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      state_r <= ST_IDLE;
      step_r <= 4'h0;
      sar_r <= 10'h000;
      trial_r <= 10'h000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_ok)
          begin
            state_r <= ST_CONVERT;
            step_r <= 4'h0;
            sar_r <= 10'h000;
            trial_r <= 10'h000;
          end
        end
        ST_CONVERT:
        begin
          if (conv_abort)
          begin
            state_r <= ST_HOLDOFF;
            step_r <= 4'h0;
          end
          else if (tick)
          begin
            if (step_r >= 4'h1 && step_r <= 4'(RESULT_BITS))
              sar_r <= sar_next;
            trial_r <= (step_r < 4'(RESULT_BITS)) ? (10'h200 >> step_r) : 10'h000;
            if (conv_done)
            begin
              state_r <= ST_HOLDOFF;
              step_r <= 4'h0;
            end
            else
              step_r <= step_r + 4'h1;
          end
        end
        ST_HOLDOFF:
        begin
          if (tick)
          begin
            if (step_r == 4'(HOLDOFF_PERIODS - 1))
              state_r <= ST_IDLE;
            step_r <= step_r + 4'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Justified result; filler bits forced to zero
  wire [15:0] just_result = port_config_r[FORMAT_BIT] ? {6'h00, sar_r}
                                                     : {sar_r, 6'h00};

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      result_high_r <= 8'h00;
      result_low_r <= 8'h00;
      irq_flag_r <= 1'b0;
    end
    else
    begin
      // Result bytes double as scratch registers while unused
      if (conv_done)
      begin
        result_high_r <= just_result[15:8];
        result_low_r <= just_result[7:0];
      end
      else if (bus_wr && hit_high)
        result_high_r <= PWDATA[7:0];
      else if (bus_wr && hit_low)
        result_low_r <= PWDATA[7:0];
      // Set wins over a software clear in the same cycle
      if (conv_done)
        irq_flag_r <= 1'b1;
      else if (wr_status && PWDATA[0])
        irq_flag_r <= 1'b0;
    end
  end

  // Pin map per configuration code; absent channels masked off
  logic [7:0] pin_map;
  wire pos_ext = pcfg == 4'h1 || pcfg == 4'h3 || pcfg == 4'h5 || pcfg == 4'h8 ||
                 (pcfg >= 4'ha && pcfg != 4'he);
  wire neg_ext = pcfg == 4'h8 || (pcfg >= 4'hb && pcfg != 4'he);
  always_comb
  begin
    case (pcfg)
      4'h0: pin_map = 8'hff;
      4'h1: pin_map = 8'hf7;
      4'h2: pin_map = 8'h1f;
      4'h3: pin_map = 8'h17;
      4'h4: pin_map = 8'h0b;
      4'h5: pin_map = 8'h03;
      4'h6, 4'h7: pin_map = 8'h00;
      4'h8: pin_map = 8'hf3;
      4'h9: pin_map = 8'h3f;
      4'ha: pin_map = 8'h37;
      4'hb: pin_map = 8'h33;
      4'hc: pin_map = 8'h13;
      4'hd: pin_map = 8'h03;
      4'he: pin_map = 8'h01;
      default: pin_map = 8'h01;
    endcase
  end
  wire [7:0] present_mask = (NUM_CHANNELS == 5) ? 8'h1f : 8'hff;

  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_control)
      rd_data = {24'h000000, control_r};
    else if (hit_config)
      rd_data = {24'h000000, port_config_r};
    else if (hit_high)
      rd_data = {24'h000000, result_high_r};
    else if (hit_low)
      rd_data = {24'h000000, result_low_r};
    else if (hit_status)
      rd_data = {31'h0000_0000, irq_flag_r};
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      TRIAL_LEVEL <= 10'h000;
      CHANNEL_ROUTE <= 3'h0;
      SAMPLE_CONNECT <= 1'b0;
      MODULE_POWERED <= 1'b0;
      RC_OSC_ENABLE <= 1'b0;
      ANALOG_PINS <= 8'h00;
      POS_REF_EXTERNAL <= 1'b0;
      NEG_REF_EXTERNAL <= 1'b0;
      CONVERTER_IRQ_FLAG <= 1'b0;
    end
    else
    begin
      // One wait state: ready in the cycle after the access phase opens
      PREADY <= PSEL && PENABLE && !PREADY;
      PRDATA <= rd_data;
      PSLVERR <= PSEL && PENABLE && !PREADY && !hit_any;
      TRIAL_LEVEL <= sar_r | trial_r;
      CHANNEL_ROUTE <= control_r[CHAN_LSB +: 3];
      // Hold capacitor off the channel during conversion and holdoff
      SAMPLE_CONNECT <= powered && state_r == ST_IDLE;
      MODULE_POWERED <= powered;
      RC_OSC_ENABLE <= powered && clksel == 2'(CLK_RC);
      ANALOG_PINS <= pin_map & present_mask;
      POS_REF_EXTERNAL <= pos_ext;
      NEG_REF_EXTERNAL <= neg_ext;
      CONVERTER_IRQ_FLAG <= irq_flag_r;
    end
  end

endmodule : adcc_top

/* adcc_pkg.sv */
package adcc_pkg;
  localparam logic [7:0] IDX_CONTROL = 8'h1f;
  localparam logic [7:0] IDX_PORT_CONFIG = 8'h9f;
  // One word per register: byte address is four times the index
  localparam logic [11:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_PORT_CONFIG = {2'h0, IDX_PORT_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_RESULT_HIGH = 12'h400;
  localparam logic [11:0] ADDR_RESULT_LOW = 12'h404;
  localparam logic [11:0] ADDR_STATUS = 12'h408;
  localparam int CLKSEL_LSB = 6;
  localparam int CHAN_LSB = 3;
  localparam int START_BIT = 2;
  localparam int POWER_BIT = 0;
  localparam int FORMAT_BIT = 7;
  localparam logic [7:0] CONTROL_MASK = 8'hfd;
  localparam logic [7:0] PORT_CONFIG_MASK = 8'h8f;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_CONFIG_RESET = 8'h00;
  localparam int CONV_PERIODS = 12;
  localparam int HOLDOFF_PERIODS = 2;
  localparam int RESULT_BITS = 10;
  typedef enum logic [1:0] {CLK_DIV2, CLK_DIV8, CLK_DIV32, CLK_RC} adcc_clksel_t;
  typedef enum {ST_IDLE, ST_CONVERT, ST_HOLDOFF} adcc_state_t;
endpackage : adcc_pkg

/* adcc_properties.sv */
`timescale 1ns/10ps
module adcc_properties
  import adcc_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
)
(
  input logic SYS_CLK, // Clock
  input logic SRST, // Reset
  input logic PSEL, // Select
  input logic PENABLE, // Access
  input logic PREADY, // Ready
  input logic PSLVERR, // Error
  input logic [31:0] PRDATA, // Read data
  input logic SAMPLE_CONNECT, // Switch
  input logic MODULE_POWERED, // Power
  input logic RC_OSC_ENABLE, // RC clock
  input logic [7:0] ANALOG_PINS, // Pin map
  input logic POS_REF_EXTERNAL, // Ref high
  input logic NEG_REF_EXTERNAL, // Ref low
  input logic CONVERTER_IRQ_FLAG // Flag
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);
  ready_follows_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
  err_with_ready_a: assert property (PSLVERR |-> PREADY) else $error("stray error");
  read_width_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper bits set");
  rc_power_a: assert property (RC_OSC_ENABLE |-> MODULE_POWERED) else $error("rc unpowered");
  off_no_sample_a: assert property (!MODULE_POWERED |-> !SAMPLE_CONNECT) else $error("sampling off");
  // Switch stays open for the first three cycles after each new flag
  holdoff_gap_a: assert property ($rose(CONVERTER_IRQ_FLAG) |-> !SAMPLE_CONNECT [*3]) else $error("early sample");
  conv_length_a: assert property ($fell(SAMPLE_CONNECT) |=> (!$rose(CONVERTER_IRQ_FLAG)) [*8]) else $error("short");
  small_pins_a: assert property ((NUM_CHANNELS == 5) |-> ANALOG_PINS[7:5] == 3'h0) else $error("pins 5-7");
  ref_pair_a: assert property (NEG_REF_EXTERNAL |-> POS_REF_EXTERNAL && ANALOG_PINS[3:2] == 2'h0) else $error("refs");
  pos_ref_pin_a: assert property (POS_REF_EXTERNAL |-> !ANALOG_PINS[3]) else $error("ref pin analog");
  cover property ($rose(CONVERTER_IRQ_FLAG));
  cover property (PSLVERR);
  cover property (RC_OSC_ENABLE && !SAMPLE_CONNECT);
endmodule : adcc_properties
bind adcc_top adcc_properties #(.NUM_CHANNELS(NUM_CHANNELS)) u_props (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .SAMPLE_CONNECT(SAMPLE_CONNECT),
  .MODULE_POWERED(MODULE_POWERED), .RC_OSC_ENABLE(RC_OSC_ENABLE), .ANALOG_PINS(ANALOG_PINS),
  .POS_REF_EXTERNAL(POS_REF_EXTERNAL), .NEG_REF_EXTERNAL(NEG_REF_EXTERNAL), .CONVERTER_IRQ_FLAG(CONVERTER_IRQ_FLAG));

/* adcc_analog_model.sv */
`timescale 1ns/10ps
module adcc_analog_model (
  input wire logic clk, // Clock
  input wire logic [2:0] channel_route, // Channel
  input wire logic sample_connect, // Switch
  input wire logic [9:0] trial_level, // Trial
  output logic [9:0] comparator_high // Compare
);
  logic [9:0] held_r;
  // Charge frozen while the switch is open, so late channel changes do not leak in
  always_ff @(posedge clk)
  begin
    if (sample_connect)
      held_r <= 10'h2a5 ^ {7'h0, channel_route};
  end
  assign comparator_high = (held_r >= trial_level) ? 10'h3ff : 10'h000;
endmodule : adcc_analog_model

/* adcc_top_test.sv */
`timescale 1ns/10ps
module adcc_top_test;
  import adcc_pkg::*;
  localparam int RC_DIV = 4;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, samp, powered, rc_en, pos_ext, neg_ext, flag, err;
  logic [9:0] comp, trial;
  logic [2:0] route;
  logic [7:0] pins;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  adcc_top #(.NUM_CHANNELS(8), .RC_DIV(RC_DIV)) dut (.SYS_CLK(sys_clk), .SRST(srst), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .COMPARATOR_HIGH(comp), .TRIAL_LEVEL(trial), .CHANNEL_ROUTE(route), .SAMPLE_CONNECT(samp),
    .MODULE_POWERED(powered), .RC_OSC_ENABLE(rc_en), .ANALOG_PINS(pins), .POS_REF_EXTERNAL(pos_ext),
    .NEG_REF_EXTERNAL(neg_ext), .CONVERTER_IRQ_FLAG(flag));
  adcc_analog_model model (.clk(sys_clk), .channel_route(route), .sample_connect(samp), .trial_level(trial),
    .comparator_high(comp));
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
    begin
      fail_count++;
      stop_test();
    end
  endtask : apb
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk
  task automatic t_regs;
    chk("reset outputs", 32'h0, {22'h0, powered, flag, pins});
    rchk("control reset", ADDR_CONTROL, 32'h0);
    rchk("config reset", ADDR_PORT_CONFIG, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'hfffffffa);
    rchk("control bits", ADDR_CONTROL, 32'hf8);
    apb(1'b1, ADDR_PORT_CONFIG, 32'hff);
    rchk("config bits", ADDR_PORT_CONFIG, 32'h8f);
    rchk("unmapped", 12'h100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("Test registers done");
  endtask : t_regs
  task automatic t_pins;
    logic [9:0] map [16] = '{10'h0ff, 10'h2f7, 10'h01f, 10'h217, 10'h00b, 10'h203, 10'h000, 10'h000,
      10'h3f3, 10'h03f, 10'h237, 10'h333, 10'h313, 10'h303, 10'h001, 10'h301};
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, ADDR_PORT_CONFIG, 32'(i));
      repeat (2) @(posedge sys_clk);
      chk("pin map", {22'h0, map[i]}, {22'h0, pos_ext, neg_ext, pins});
    end
    $display("Test pins done");
  endtask : t_pins
  task automatic t_conv;
    logic [9:0] v;
    logic [31:0] ctl;
    int n, t0, per;
    for (int i = 0; i < 8; i++)
    begin
      v = 10'h2a5 ^ {7'h0, i[2:0]};
      ctl = {24'h0, i[1:0], i[2:0], 3'h1};
      per = (i[1:0] == 2'h3) ? RC_DIV : 2 << (2 * i[1:0]);
      apb(1'b1, ADDR_PORT_CONFIG, {24'h0, i[0], 7'h0});
      apb(1'b1, ADDR_CONTROL, ctl);
      apb(1'b1, ADDR_STATUS, 32'h1);
      for (n = 0; n < 200 && samp !== 1'b1; n++)
        @(posedge sys_clk);
      repeat (8) @(posedge sys_clk);
      chk("acquire", 32'h1, {31'h0, samp});
      chk("route", {29'h0, i[2:0]}, {29'h0, route});
      chk("rc clock", {31'h0, i[1:0] == 2'h3}, {31'h0, rc_en});
      apb(1'b1, ADDR_CONTROL, ctl | 32'h4);
      t0 = cyc;
      rd = 32'h4;
      for (n = 0; n < 300 && rd[2] !== 1'b0; n++)
        apb(1'b0, ADDR_CONTROL, 32'h0);
      chk("conversion time", 32'h1, {31'h0, (cyc - t0) >= 12 * per - 3 && n < 300});
      chk("flag pin", 32'h1, {31'h0, flag});
      rchk("status", ADDR_STATUS, 32'h1);
      rchk("result high", ADDR_RESULT_HIGH, i[0] ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
      rchk("result low", ADDR_RESULT_LOW, i[0] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0});
      rchk("control after", ADDR_CONTROL, ctl);
    end
    $display("Test conversions done");
  endtask : t_conv
  task automatic t_abort;
    apb(1'b1, ADDR_STATUS, 32'h1);
    apb(1'b1, ADDR_CONTROL, 32'h04);
    repeat (40) @(posedge sys_clk);
    chk("unpowered start", 32'h0, {30'h0, flag, powered});
    apb(1'b1, ADDR_CONTROL, 32'h81);
    repeat (8) @(posedge sys_clk);
    apb(1'b1, ADDR_CONTROL, 32'h85);
    repeat (20) @(posedge sys_clk);
    apb(1'b1, ADDR_CONTROL, 32'h81);
    repeat (400) @(posedge sys_clk);
    chk("abort flag", 32'h0, {31'h0, flag});
    rchk("kept high", ADDR_RESULT_HIGH, 32'h02);
    rchk("kept low", ADDR_RESULT_LOW, 32'ha2);
    $display("Test abort done");
  endtask : t_abort
  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_pins();
    t_conv();
    t_abort();
    stop_test();
  end
endmodule : adcc_top_test
